// file: inc/gas_status_map.vh
`ifndef GAS_STATUS_MAP_VH
`define GAS_STATUS_MAP_VH

// Clock and base tick
`define CLK_FREQ_HZ 25000000
`define TICK_TIME_MS 1
`define TICK_CYCLES (`CLK_FREQ_HZ / 1000 * `TICK_TIME_MS)

// Power-up sequence, in milliseconds of tick
`define LAMP_TEST_MS 200
`define SETTLE_TIME_S 2
`define SETTLE_MS (`SETTLE_TIME_S * 1000)
`define WARMUP_TIME_S 60
`define WARMUP_MS (`WARMUP_TIME_S * 1000)

// Auxiliary indication and jumper hold times
`define AUX_ON_MS 11'h7d0
`define LIFE_JUMPER_TIME_S 10
`define LIFE_JUMPER_MS (`LIFE_JUMPER_TIME_S * 1000)
`define SETTINGS_JUMPER_TIME_S 5
`define SETTINGS_JUMPER_MS (`SETTINGS_JUMPER_TIME_S * 1000)

// Polling activity and daily lifetime store
`define POLL_TIMEOUT_MS 2000
`define STORE_PERIOD_H 24
`define STORE_PERIOD_MS (`STORE_PERIOD_H * 3600 * 1000)
`define SUSPEND_MS 9'h12c

// Blink timing
`define SLOW_HALF_MS 500
`define PREALARM_HALF_MS 250
`define BUZZ_HALF_MS 500
`define BLINK_FRAME_MS 1000
`define FAULT_ON_MS 250
`define FAULT_OFF_MS 250
`define FAULT_PAUSE_MS 1500

// Communication and lifetime defaults
`define DEFAULT_ADDRESS 7'h01
`define DEFAULT_BAUD 17'h02580
`define DEFAULT_LIFE_DAYS 11'h721

// Gas type codes
`define GAS_METHANE 2'h0
`define GAS_VAPOUR 2'h1
`define GAS_CO 2'h2
`define GAS_LPG 2'h3

// Power-up phases
`define PH_LAMP 2'h0
`define PH_SETTLE 2'h1
`define PH_WARMUP 2'h2
`define PH_RUN 2'h3

`endif

// file: rtl/fault_blinker.v
`timescale 1ns/1ps
`include "gas_status_map.vh"

module fault_blinker (
   input wire clk,
   input wire rst,
   input wire tick,
   input wire [3:0] blinks,
   output reg led
);
   reg [10:0] phase_ms;
   reg [3:0] done;
   reg [3:0] group;
   reg in_pause;

   // Count is latched per group so a change never splits a group
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         phase_ms <= 11'h000;
         done <= 4'h0;
         group <= 4'h0;
         in_pause <= 1'b1;
         led <= 1'b0;
      end else if (tick) begin
         phase_ms <= phase_ms + 11'h001;
         if (in_pause) begin
            led <= 1'b0;
            if (phase_ms >= `FAULT_PAUSE_MS - 1) begin
               phase_ms <= 11'h000;
               group <= blinks;
               done <= 4'h0;
               in_pause <= (blinks == 4'h0);
               led <= (blinks != 4'h0);
            end
         end else if (led) begin
            if (phase_ms >= `FAULT_ON_MS - 1) begin
               phase_ms <= 11'h000;
               led <= 1'b0;
               done <= done + 4'h1;
            end
         end else if (phase_ms >= `FAULT_OFF_MS - 1) begin
            phase_ms <= 11'h000;
            if (done >= group) begin
               in_pause <= 1'b1;
            end else begin
               led <= 1'b1;
            end
         end
      end
   end
endmodule // fault_blinker

// file: rtl/gas_status_indicator.v
`timescale 1ns/1ps
`include "gas_status_map.vh"

// Summary of operation
// - Brief lamp test, then fault, alarm, supply lit 2 s while converter settles.
// - Warm-up: supply blinks slowly, gas detection unavailable until warm-up ends.
// - After warm-up with bus polling, supply toggles at each poll.
// - After warm-up without polling, supply stays steadily on.
// - Fault blinks: 1 supply range, 2 sensor fault, 4 end of life, sums combine.
// - Flash write error alone gives 8; combinations use listed counts 9 to 15.
// - Fault steady on for memory errors, off when no fault.
// - Alarm indicator blinks above pre-alarm threshold.
// - Alarm indicator steady above alarm threshold, overriding pre-alarm blink.
// - Aux indicator on 2 s after life, settings, comm reset or bus module reset.
// - Comm reset restores address 01 and baud 9600.
// - With expansion fitted, buzzer steady in alarm, intermittent in pre-alarm.
// - Track sensor validity and life; toxic sensor keeps its own life.
// - Gas type decoded from two switches.
// - Range switch on selects high range, off low range.
// - Bus address is ten times tens switch plus units switch, or the stored address when both switches are zero.
// - Bus drives a differential RS485 A/B pair shared with the master.
// - Address and baud changes apply only at board reset coil or power-up.
// - Every 24 h store lifetime and suspend bus about 300 ms.
// - Board or sensor failure forces the 2.0 mA loop fault level.
module gas_status_indicator #(
   parameter TICK_CYCLES = `TICK_CYCLES,
   parameter WARMUP_MS = `WARMUP_MS,
   parameter STORE_PERIOD_MS = `STORE_PERIOD_MS,
   parameter LIFE_JUMPER_MS = `LIFE_JUMPER_MS,
   parameter SETTINGS_JUMPER_MS = `SETTINGS_JUMPER_MS
) (
   input wire clk,
   input wire rst,
   input wire gas_type_switch_a,
   input wire gas_type_switch_b,
   input wire range_select_switch,
   input wire [3:0] address_tens_switch,
   input wire [3:0] address_units_switch,
   input wire life_reset_jumper,
   input wire settings_reset_jumper,
   input wire supply_out_of_range,
   input wire sensor_fault,
   input wire flash_write_error,
   input wire memory_error,
   input wire module_life_expired,
   input wire pre_alarm_exceeded,
   input wire alarm_exceeded,
   input wire expansion_fitted,
   input wire poll_strobe,
   input wire life_reset_cmd,
   input wire settings_reset_cmd,
   input wire comm_reset_cmd,
   input wire board_reset_coil,
   input wire address_write,
   input wire [6:0] write_address,
   input wire baud_write,
   input wire [16:0] write_baud,
   input wire uart_tx,
   input wire uart_tx_en,
   output wire uart_rx,
   input wire rs485_a_in,
   output reg rs485_a_out,
   output reg rs485_a_oe_n,
   input wire rs485_b_in,
   output reg rs485_b_out,
   output reg rs485_b_oe_n,
   output reg aux_indicator,
   output reg fault_indicator,
   output reg alarm_indicator,
   output reg supply_indicator,
   output reg buzzer,
   output reg [1:0] gas_type,
   output reg range_high,
   output reg [6:0] bus_address,
   output reg [16:0] baud_rate,
   output reg detect_ready,
   output reg comm_suspend,
   output reg life_store,
   output reg settings_restore,
   output reg sensor_valid,
   output reg sensor_end_life,
   output reg loop_fault_2ma
);
   // Decode of combined fault flags to a blink count
   function [3:0] fault_blinks;
      input flash_err;
      input [2:0] low;
      begin
         if (!flash_err) begin
            fault_blinks = {1'b0, low};
         end else begin
            case (low)
               3'h0: fault_blinks = 4'h8;
               3'h1: fault_blinks = 4'h9;
               3'h2: fault_blinks = 4'ha;
               3'h3: fault_blinks = 4'hc;
               3'h4: fault_blinks = 4'hb;
               3'h6: fault_blinks = 4'hd;
               3'h7: fault_blinks = 4'he;
               default: fault_blinks = 4'hf;
            endcase
         end
      end
   endfunction

   wire tick;
   wire fault_blink_led;
   wire [14:0] async_in;
   reg [14:0] sync_1;
   reg [14:0] sync_2;
   reg [1:0] phase;
   reg [16:0] phase_ms;
   reg [9:0] frame_ms;
   reg [11:0] poll_idle_ms;
   reg poll_toggle;
   reg [10:0] aux_ms;
   reg [13:0] life_hold_ms;
   reg [13:0] set_hold_ms;
   reg life_fired;
   reg set_fired;
   reg [26:0] day_ms;
   reg [8:0] suspend_ms;
   reg [10:0] elapsed_days;
   reg [6:0] stored_address;
   reg [16:0] stored_baud;
   wire [6:0] switch_address;
   wire life_jump_ev;
   wire set_jump_ev;
   wire life_ev;
   wire comm_ev;
   wire settings_ev;
   wire life_end;
   wire [3:0] blink_count;

   assign async_in = {rs485_b_in, rs485_a_in, settings_reset_jumper, life_reset_jumper,
                      address_units_switch, address_tens_switch, range_select_switch,
                      gas_type_switch_b, gas_type_switch_a};

   // Two-stage synchronisers for the switch, jumper and RS485 receive pair inputs
   genvar gi;
   generate
      for (gi = 0; gi < 15; gi = gi + 1) begin : g_sync
         always @(posedge clk or posedge rst) begin
            if (rst) begin
               sync_1[gi] <= 1'b0;
               sync_2[gi] <= 1'b0;
            end else begin
               sync_1[gi] <= async_in[gi];
               sync_2[gi] <= sync_1[gi];
            end
         end
      end
   endgenerate

   tick_divider #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_tick (
      .clk(clk),
      .rst(rst),
      .tick(tick)
   );

   assign blink_count = fault_blinks(flash_write_error, {sensor_end_life, sensor_fault, supply_out_of_range});

   fault_blinker u_fault (
      .clk(clk),
      .rst(rst),
      .tick(tick),
      .blinks(blink_count),
      .led(fault_blink_led)
   );

   // Tens times ten as shifts keeps it to adders
   assign switch_address = {sync_2[6:3], 3'h0} + {2'h0, sync_2[6:3], 1'h0} + {3'h0, sync_2[10:7]};

   // Jumper holds: warm-up window for life and settings, run phase for comm
   assign life_jump_ev = tick && !life_fired && (life_hold_ms == LIFE_JUMPER_MS - 1) && (phase == `PH_WARMUP);
   assign set_jump_ev = tick && !set_fired && (set_hold_ms == SETTINGS_JUMPER_MS - 1);
   assign life_ev = life_jump_ev || life_reset_cmd;
   assign settings_ev = (set_jump_ev && phase == `PH_WARMUP) || settings_reset_cmd;
   assign comm_ev = (set_jump_ev && phase == `PH_RUN) || comm_reset_cmd;
   assign life_end = (gas_type == `GAS_CO) ? module_life_expired : (elapsed_days >= `DEFAULT_LIFE_DAYS);

   // Power-up phase sequencer
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         phase <= `PH_LAMP;
         phase_ms <= 17'h00000;
      end else if (tick) begin
         phase_ms <= phase_ms + 17'h00001;
         case (phase)
            `PH_LAMP: if (phase_ms >= `LAMP_TEST_MS - 1) begin
               phase <= `PH_SETTLE;
               phase_ms <= 17'h00000;
            end
            `PH_SETTLE: if (phase_ms >= `SETTLE_MS - 1) begin
               phase <= `PH_WARMUP;
               phase_ms <= 17'h00000;
            end
            `PH_WARMUP: if (phase_ms >= WARMUP_MS - 1) begin
               phase <= `PH_RUN;
               phase_ms <= 17'h00000;
            end
            default: phase_ms <= 17'h00000;
         endcase
      end
   end

   // Free-running blink frame plus poll activity, jumper and aux timers
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         frame_ms <= 10'h000;
         poll_idle_ms <= 12'hfff;
         poll_toggle <= 1'b0;
         aux_ms <= 11'h000;
         life_hold_ms <= 14'h0000;
         set_hold_ms <= 14'h0000;
         life_fired <= 1'b0;
         set_fired <= 1'b0;
      end else begin
         if (poll_strobe) begin
            poll_toggle <= ~poll_toggle;
            poll_idle_ms <= 12'h000;
         end else if (tick && poll_idle_ms < `POLL_TIMEOUT_MS) begin
            poll_idle_ms <= poll_idle_ms + 12'h001;
         end
         if (life_ev || settings_ev || comm_ev || board_reset_coil) begin
            aux_ms <= `AUX_ON_MS;
         end else if (tick && aux_ms != 11'h000) begin
            aux_ms <= aux_ms - 11'h001;
         end
         if (tick) begin
            frame_ms <= (frame_ms >= `BLINK_FRAME_MS - 1) ? 10'h000 : frame_ms + 10'h001;
            life_hold_ms <= (sync_2[11] && !life_fired) ? life_hold_ms + 14'h0001 : 14'h0000;
            set_hold_ms <= (sync_2[12] && !set_fired) ? set_hold_ms + 14'h0001 : 14'h0000;
         end
         // Fire once per closure; released jumper rearms
         if (life_jump_ev) begin
            life_fired <= 1'b1;
         end else if (!sync_2[11]) begin
            life_fired <= 1'b0;
         end
         if (set_jump_ev) begin
            set_fired <= 1'b1;
         end else if (!sync_2[12]) begin
            set_fired <= 1'b0;
         end
      end
   end

   // Communication settings: staged writes, applied only at board reset or power-up
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         stored_address <= `DEFAULT_ADDRESS;
         stored_baud <= `DEFAULT_BAUD;
         bus_address <= `DEFAULT_ADDRESS;
         baud_rate <= `DEFAULT_BAUD;
         settings_restore <= 1'b0;
      end else begin
         settings_restore <= settings_ev;
         if (comm_ev) begin
            stored_address <= `DEFAULT_ADDRESS;
            stored_baud <= `DEFAULT_BAUD;
         end else begin
            if (address_write) begin
               stored_address <= write_address;
            end
            if (baud_write) begin
               stored_baud <= write_baud;
            end
         end
         // Switch address wins when set; zero falls back to the stored one
         if (board_reset_coil || (tick && phase == `PH_LAMP && phase_ms == 17'h00000)) begin
            bus_address <= (switch_address != 7'h00) ? switch_address : stored_address;
            baud_rate <= stored_baud;
         end
      end
   end

   // Daily lifetime store with bus suspend; sensor life bookkeeping
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         day_ms <= 27'h0000000;
         suspend_ms <= 9'h000;
         life_store <= 1'b0;
         comm_suspend <= 1'b0;
         elapsed_days <= 11'h000;
      end else begin
         life_store <= 1'b0;
         if (tick) begin
            if (day_ms >= STORE_PERIOD_MS - 1) begin
               day_ms <= 27'h0000000;
               life_store <= 1'b1;
               suspend_ms <= `SUSPEND_MS;
            end else begin
               day_ms <= day_ms + 27'h0000001;
               if (suspend_ms != 9'h000) begin
                  suspend_ms <= suspend_ms - 9'h001;
               end
            end
         end
         comm_suspend <= (suspend_ms != 9'h000);
         // Base-board life only; the toxic sensor module counts its own
         if (life_ev) begin
            elapsed_days <= 11'h000;
         end else if (tick && day_ms >= STORE_PERIOD_MS - 1 && gas_type != `GAS_CO && !life_end) begin
            elapsed_days <= elapsed_days + 11'h001;
         end
      end
   end

   // Indicators, buzzer, switch decode and fault status
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         aux_indicator <= 1'b0;
         fault_indicator <= 1'b0;
         alarm_indicator <= 1'b0;
         supply_indicator <= 1'b0;
         buzzer <= 1'b0;
         gas_type <= `GAS_METHANE;
         range_high <= 1'b0;
         detect_ready <= 1'b0;
         sensor_valid <= 1'b0;
         sensor_end_life <= 1'b0;
         loop_fault_2ma <= 1'b0;
      end else begin
         gas_type <= sync_2[1] ? (sync_2[0] ? `GAS_LPG : `GAS_CO) : (sync_2[0] ? `GAS_VAPOUR : `GAS_METHANE);
         range_high <= sync_2[2];
         detect_ready <= (phase == `PH_RUN);
         sensor_end_life <= life_end;
         sensor_valid <= !sensor_fault && !life_end;
         loop_fault_2ma <= sensor_fault || memory_error;
         aux_indicator <= (phase == `PH_LAMP) || (aux_ms != 11'h000);
         buzzer <= expansion_fitted && (phase == `PH_RUN) &&
                   (alarm_exceeded || (pre_alarm_exceeded && frame_ms < `BUZZ_HALF_MS));
         case (phase)
            `PH_LAMP, `PH_SETTLE: begin
               fault_indicator <= 1'b1;
               alarm_indicator <= 1'b1;
               supply_indicator <= 1'b1;
            end
            default: begin
               if (memory_error) begin
                  fault_indicator <= 1'b1;
               end else begin
                  fault_indicator <= fault_blink_led;
               end
               if (phase != `PH_RUN) begin
                  alarm_indicator <= 1'b0;
                  supply_indicator <= (frame_ms < `SLOW_HALF_MS);
               end else begin
                  if (alarm_exceeded) begin
                     alarm_indicator <= 1'b1;
                  end else if (pre_alarm_exceeded) begin
                     alarm_indicator <= (frame_ms < `PREALARM_HALF_MS) ||
                                        (frame_ms >= 2 * `PREALARM_HALF_MS && frame_ms < 3 * `PREALARM_HALF_MS);
                  end else begin
                     alarm_indicator <= 1'b0;
                  end
                  if (poll_idle_ms < `POLL_TIMEOUT_MS) begin
                     supply_indicator <= poll_toggle;
                  end else begin
                     supply_indicator <= 1'b1;
                  end
               end
            end
         endcase
      end
   end

   // RS485 pair: A carries data, B its complement; released during suspend
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         rs485_a_out <= 1'b1;
         rs485_b_out <= 1'b0;
         rs485_a_oe_n <= 1'b1;
         rs485_b_oe_n <= 1'b1;
      end else begin
         rs485_a_out <= uart_tx;
         rs485_b_out <= ~uart_tx;
         rs485_a_oe_n <= !(uart_tx_en && suspend_ms == 9'h000);
         rs485_b_oe_n <= !(uart_tx_en && suspend_ms == 9'h000);
      end
   end

   // Idle or undriven pair reads as mark, so only B above A gives a zero
   assign uart_rx = !(!sync_2[13] & sync_2[14]);
endmodule // gas_status_indicator

// file: rtl/tick_divider.v
`timescale 1ns/1ps
`include "gas_status_map.vh"

module tick_divider #(
   parameter TICK_CYCLES = `TICK_CYCLES
) (
   input wire clk,
   input wire rst,
   output reg tick
);
   reg [15:0] count;

   // One-cycle enable every tick period, restarted at power-up
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         count <= 16'h0000;
         tick <= 1'b0;
      end else if (count == TICK_CYCLES - 1) begin
         count <= 16'h0000;
         tick <= 1'b1;
      end else begin
         count <= count + 16'h0001;
         tick <= 1'b0;
      end
   end
endmodule // tick_divider

// file: verif/control_master.sv
`timescale 1ns/1ps
// Polling master: start bit on the pair, then one poll
module control_master #(
   parameter PERIOD = 50
) (
   input wire clk,
   input wire rst,
   input wire poll_en,
   input wire comm_suspend,
   output reg poll_strobe,
   output reg rs485_a_in,
   output reg rs485_b_in
);
   localparam [7:0] LAST = PERIOD - 1;
   reg [7:0] cnt;
   wire frame;
   // Holds off during the store gap instead of retrying
   assign frame = poll_en && !comm_suspend;
   // Bias resistors pull the idle pair to mark
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt <= 8'h00;
         poll_strobe <= 1'b0;
         rs485_a_in <= 1'b1;
         rs485_b_in <= 1'b0;
      end else begin
         cnt <= (cnt == LAST) ? 8'h00 : cnt + 8'h01;
         poll_strobe <= frame && cnt == LAST;
         rs485_a_in <= !(frame && cnt < 8'h04);
         rs485_b_in <= frame && cnt < 8'h04;
      end
   end
endmodule // control_master

// file: verif/gas_status_indicator_sva.sv
`timescale 1ns/1ps
// Port-level timing checks on the indicator block
module gas_status_checker (
   input wire clk,
   input wire rst,
   input wire gas_type_switch_a,
   input wire gas_type_switch_b,
   input wire sensor_fault,
   input wire memory_error,
   input wire alarm_exceeded,
   input wire expansion_fitted,
   input wire comm_reset_cmd,
   input wire board_reset_coil,
   input wire uart_tx_en,
   input wire rs485_a_out,
   input wire rs485_a_oe_n,
   input wire rs485_b_out,
   input wire rs485_b_oe_n,
   input wire aux_indicator,
   input wire fault_indicator,
   input wire alarm_indicator,
   input wire buzzer,
   input wire [1:0] gas_type,
   input wire [6:0] bus_address,
   input wire detect_ready,
   input wire comm_suspend,
   input wire loop_fault_2ma
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Suspend must hold the pair quiet from its second cycle on
   sequence held_suspend;
      comm_suspend ##1 comm_suspend;
   endsequence
   // Switches left alone long enough to pass the synchronisers
   sequence gas_still;
      ($stable(gas_type_switch_a) && $stable(gas_type_switch_b)) [*5];
   endsequence
   chk_oe_idle: assert property (!uart_tx_en |=> rs485_a_oe_n && rs485_b_oe_n)
      else $error("pair driven while idle");
   chk_pair_diff: assert property (!rs485_a_oe_n |-> rs485_a_out != rs485_b_out)
      else $error("pair not differential");
   chk_suspend_quiet: assert property (held_suspend |-> rs485_a_oe_n && rs485_b_oe_n)
      else $error("pair driven in suspend");
   chk_loop_fault: assert property ((sensor_fault || memory_error) [*2] |-> loop_fault_2ma)
      else $error("loop fault level missing");
   chk_alarm_steady: assert property ((detect_ready && alarm_exceeded) [*3] |-> alarm_indicator)
      else $error("alarm not steady");
   chk_buzz_steady: assert property ((detect_ready && alarm_exceeded && expansion_fitted) [*3] |-> buzzer)
      else $error("buzzer not steady");
   chk_buzz_absent: assert property ((!expansion_fitted) [*3] |-> !buzzer)
      else $error("buzzer without board");
   chk_mem_steady: assert property ((detect_ready && memory_error) [*3] |-> fault_indicator)
      else $error("memory fault not steady");
   chk_aux_start: assert property (comm_reset_cmd || board_reset_coil |-> ##[1:2] aux_indicator)
      else $error("aux late");
   chk_addr_hold: assert property (detect_ready && !board_reset_coil && !$past(board_reset_coil) |=> $stable(bus_address))
      else $error("address changed early");
   chk_gas_decode: assert property (gas_still |-> gas_type == {gas_type_switch_b, gas_type_switch_a})
      else $error("gas type wrong");
endmodule // gas_status_checker

bind gas_status_indicator gas_status_checker u_gas_status_checker (.*);

// file: verif/test_gas_status_indicator.sv
`timescale 1ns/1ps
module test_gas_status_indicator;
   localparam TK = 3;
   reg clk, rst, gas_type_switch_a, gas_type_switch_b, range_select_switch, poll_en;
   reg [3:0] address_tens_switch, address_units_switch;
   reg supply_out_of_range, sensor_fault, flash_write_error, memory_error;
   reg pre_alarm_exceeded, alarm_exceeded, expansion_fitted, comm_reset_cmd, board_reset_coil, life_reset_cmd;
   reg settings_reset_cmd, module_life_expired;
   reg address_write, baud_write, uart_tx, uart_tx_en;
   reg [6:0] write_address, a0, wa;
   reg [16:0] write_baud;
   wire poll_strobe, rs485_a_in, rs485_b_in, rs485_a_out, rs485_a_oe_n, rs485_b_out, rs485_b_oe_n;
   wire aux_indicator, fault_indicator, alarm_indicator, supply_indicator, buzzer, range_high;
   wire detect_ready, comm_suspend, loop_fault_2ma, uart_rx, settings_restore;
   wire [1:0] gas_type;
   wire [6:0] bus_address;
   wire [16:0] baud_rate;
   int fails, n_checks, n, p, low_run, max_low;
   int cnt[5];

   gas_status_indicator #(.TICK_CYCLES(TK), .WARMUP_MS(2500), .STORE_PERIOD_MS(9000), .LIFE_JUMPER_MS(20),
      .SETTINGS_JUMPER_MS(10)) u_gas_status_indicator (.*, .life_reset_jumper(1'b0),
      .settings_reset_jumper(1'b0), .life_store(), .sensor_valid(), .sensor_end_life());
   control_master #(.PERIOD(50)) u_control_master (.*);

   // 25 MHz system clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Random transmit traffic keeps the pair drivers busy
   always @(posedge clk) begin
      uart_tx <= 1'($urandom);
      uart_tx_en <= 1'($urandom);
   end
   // Hang guard, only a little beyond the planned run
   initial begin
      repeat (100000) @(posedge clk);
      fails++;
      close_out;
   end

   function [6:0] addr_of(input [3:0] t, input [3:0] u);
      addr_of = (t == 4'h0 && u == 4'h0) ? 7'h01 : t * 7'h0a + u;
   endfunction
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task ticks(input int t);
      repeat (t * TK) @(posedge clk);
   endtask
   task coil;
      @(posedge clk);
      board_reset_coil <= 1'b1;
      @(posedge clk);
      board_reset_coil <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   // Rising edges per indicator, plus longest dark spell of fault
   task watch(input int c);
      logic [4:0] prev;
      logic [4:0] now;
      cnt = '{0, 0, 0, 0, 0};
      low_run = 0;
      max_low = 0;
      prev = {!uart_rx, buzzer, supply_indicator, alarm_indicator, fault_indicator};
      repeat (c) begin
         @(posedge clk);
         now = {!uart_rx, buzzer, supply_indicator, alarm_indicator, fault_indicator};
         for (int i = 0; i < 5; i++) if (now[i] && !prev[i]) cnt[i]++;
         low_run = fault_indicator ? 0 : low_run + 1;
         if (low_run > max_low) max_low = low_run;
         prev = now;
      end
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // Main sequence
   initial begin
      void'($urandom(44));
      {rst, poll_en, supply_out_of_range, sensor_fault, flash_write_error, memory_error} = 6'h20;
      {pre_alarm_exceeded, alarm_exceeded, expansion_fitted, comm_reset_cmd, board_reset_coil} = 5'h00;
      {life_reset_cmd, settings_reset_cmd, module_life_expired} = 3'h0;
      {address_write, baud_write, uart_tx, uart_tx_en, write_address, write_baud} = 28'h0;
      {gas_type_switch_a, gas_type_switch_b, range_select_switch} = 3'($urandom);
      address_tens_switch = 4'($urandom % 10);
      address_units_switch = 4'($urandom % 10);
      a0 = addr_of(address_tens_switch, address_units_switch);
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      check({uart_rx, aux_indicator, fault_indicator, alarm_indicator, supply_indicator}, 5'h1f);
      ticks(1000);
      check({aux_indicator, fault_indicator, alarm_indicator, supply_indicator}, 4'h7);
      check(bus_address, a0);
      for (int i = 0; i < 4; i++) begin
         {gas_type_switch_a, gas_type_switch_b, range_select_switch} <= 3'($urandom);
         repeat (6) @(posedge clk);
         check(gas_type, {gas_type_switch_b, gas_type_switch_a});
         check(range_high, range_select_switch);
      end
      $display("power-up test done");
      // Gas present during warm-up must not reach the alarm lamp
      ticks(1400);
      alarm_exceeded <= 1'b1;
      watch(2000 * TK);
      check(cnt[1], 0);
      check(cnt[2], 2);
      check(detect_ready, 1'b0);
      alarm_exceeded <= 1'b0;
      address_tens_switch <= 4'h0;
      address_units_switch <= 4'h0;
      n = 0;
      while (detect_ready !== 1'b1 && n < 1000 * TK) begin
         @(posedge clk);
         n++;
      end
      ticks(5);
      check(supply_indicator, 1'b1);
      $display("warm-up test done");
      poll_en <= 1'b1;
      repeat (60) @(posedge clk);
      watch(500);
      check(cnt[2], 5);
      check(cnt[4], 10);
      poll_en <= 1'b0;
      ticks(2100);
      check(supply_indicator, 1'b1);
      $display("poll test done");
      pre_alarm_exceeded <= 1'b1;
      expansion_fitted <= 1'b1;
      ticks(20);
      watch(1000 * TK);
      check(cnt[1], 2);
      check(cnt[3], 1);
      alarm_exceeded <= 1'b1;
      ticks(2);
      check({alarm_indicator, buzzer}, 2'h3);
      {pre_alarm_exceeded, alarm_exceeded, expansion_fitted} <= 3'h0;
      $display("alarm test done");
      memory_error <= 1'b1;
      ticks(2);
      check({fault_indicator, loop_fault_2ma}, 2'h3);
      memory_error <= 1'b0;
      ticks(400);
      check(fault_indicator, 1'b0);
      // One random low count, then the flash write error alone
      for (int k = 0; k < 2; k++) begin
         n = k ? 8 : 1 + $urandom % 3;
         p = n * 500 + 1500;
         {flash_write_error, sensor_fault, supply_out_of_range} <= {n[3], n[1], n[0]};
         ticks(p);
         watch(p * TK);
         check(cnt[0], n);
         check(max_low > 500 * TK, 1'b1);
      end
      {flash_write_error, sensor_fault, supply_out_of_range} <= 3'h0;
      $display("fault test done");
      wa = 7'(2 + $urandom % 98);
      @(posedge clk);
      {address_write, write_address, baud_write, write_baud} <= {1'b1, wa, 1'b1, 17'h04b00};
      @(posedge clk);
      {address_write, baud_write} <= 2'h0;
      ticks(2);
      check(bus_address, a0);
      coil;
      check({bus_address, baud_rate}, {wa, 17'h04b00});
      check(aux_indicator, 1'b1);
      ticks(1900);
      check(aux_indicator, 1'b1);
      ticks(200);
      check(aux_indicator, 1'b0);
      @(posedge clk);
      {comm_reset_cmd, settings_reset_cmd, life_reset_cmd} <= 3'h7;
      @(posedge clk);
      {comm_reset_cmd, settings_reset_cmd, life_reset_cmd} <= 3'h0;
      @(posedge clk);
      check(settings_restore, 1'b1);
      repeat (2) @(posedge clk);
      check(aux_indicator, 1'b1);
      coil;
      check({bus_address, baud_rate}, {7'h01, 17'h02580});
      $display("settings test done");
      close_out;
   end
endmodule // test_gas_status_indicator
